/* design/ssf_serial_port.sv */
// Serial port master: frame-pulse and SPI formats, FIFOs and APB registers
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module ssf_serial_port
    import ssf_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int WORD_WIDTH = 16
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    output logic serialClock,
    output logic slaveSelect_b,
    output logic framePulse,
    output logic txDataLine,
    output logic txDataLineOe,
    input wire logic rxDataLine
);
    localparam int PW = $clog2(FIFO_DEPTH);

    // Divider arithmetic is shared by the bit timer and the timeout limit
    function automatic logic [15:0] halfLimit(input logic [7:0] pre, input logic [7:0] rate);
        logic [15:0] half;
        half = 16'({8'h00, 1'b0, pre[7:1]} * ({8'h00, rate} + 16'h0001));
        if (half < MIN_HALF_CYCLES)
        begin
            half = MIN_HALF_CYCLES;
        end
        return half - 16'h0001;
    endfunction

    ssf_ctrl0_t ctrl0_reg;
    logic enable_reg;
    logic [7:0] prescale_reg;
    logic overrun_reg;
    logic rxTimeout_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [WORD_WIDTH-1:0] txMem [FIFO_DEPTH];
    logic [WORD_WIDTH-1:0] rxMem [FIFO_DEPTH];
    logic [PW:0] txWr_reg, txRd_reg, rxWr_reg, rxRd_reg;
    logic [2:0] rxSync_reg;
    logic rxBit_reg;
    logic [15:0] divCnt_reg;
    logic tick;
    logic [23:0] toCnt_reg;
    ssf_state_t state_reg;
    logic sck_reg, sel_reg, fs_reg, txBit_reg, oe_reg;
    logic txPop_reg, rxPush_reg, pendPush_reg;
    logic [5:0] edge_reg;
    logic [1:0] tailCnt_reg;
    logic [WORD_WIDTH-1:0] txShift_reg, rxShift_reg, rxWord_reg;

    logic txEmpty, txFull, rxEmpty, rxFull;
    logic setup, wrAccess, rdAccess, icrWrite, rxPop, pulseMode, phaseLate;
    logic [5:0] lastEdge;
    logic [3:0] msb;
    logic [23:0] toLimit;

    assign txEmpty = txWr_reg == txRd_reg;
    assign rxEmpty = rxWr_reg == rxRd_reg;
    assign txFull = txWr_reg == {~txRd_reg[PW], txRd_reg[PW-1:0]};
    assign rxFull = rxWr_reg == {~rxRd_reg[PW], rxRd_reg[PW-1:0]};
    assign setup = psel && !penable;
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && penable && !pwrite;
    assign icrWrite = wrAccess && paddr == ADDR_INT_CLEAR;
    assign rxPop = rdAccess && paddr == ADDR_DATA && !rxEmpty;
    assign pulseMode = ctrl0_reg.format == FMT_PULSE;
    // The pulse format times its bits like phase 1: rising drives, falling samples
    assign phaseLate = pulseMode || ctrl0_reg.cpha;
    assign msb = ctrl0_reg.dataSize;
    assign lastEdge = 6'({msb, 1'b1});
    assign toLimit = RX_TIMEOUT_BITS * HALVES_PER_BIT
        * ({8'h00, halfLimit(prescale_reg, ctrl0_reg.serialClockRate)} + 24'h000001);

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = pslverr_reg;
    assign serialClock = sck_reg;
    assign slaveSelect_b = sel_reg;
    assign framePulse = fs_reg;
    assign txDataLine = txBit_reg;
    assign txDataLineOe = oe_reg;

    // Control registers; zero wait states, so pready is a constant high
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ctrl0_reg <= ssf_ctrl0_t'(CTRL0_RESET);
            enable_reg <= 1'b0;
            prescale_reg <= PRESCALE_RESET;
        end
        else if (wrAccess)
        begin
            if (paddr == ADDR_CTRL0)
            begin
                ctrl0_reg <= ssf_ctrl0_t'(pwdata[15:0]);
            end
            else if (paddr == ADDR_CTRL1)
            begin
                enable_reg <= pwdata[ENABLE_BIT];
            end
            else if (paddr == ADDR_PRESCALE)
            begin
                prescale_reg <= pwdata[7:0];
            end
        end
    end

    // Read data is prepared in the setup cycle; unmapped addresses answer with an error
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            if (paddr == ADDR_CTRL0)
            begin
                prdata_reg[15:0] <= ctrl0_reg;
            end
            else if (paddr == ADDR_CTRL1)
            begin
                prdata_reg[ENABLE_BIT] <= enable_reg;
            end
            else if (paddr == ADDR_DATA)
            begin
                prdata_reg[WORD_WIDTH-1:0] <= rxMem[rxRd_reg[PW-1:0]];
            end
            else if (paddr == ADDR_STATUS)
            begin
                prdata_reg[ST_TX_EMPTY] <= txEmpty;
                prdata_reg[ST_TX_NOT_FULL] <= !txFull;
                prdata_reg[ST_RX_NOT_EMPTY] <= !rxEmpty;
                prdata_reg[ST_RX_FULL] <= rxFull;
                prdata_reg[ST_BUSY] <= state_reg != ST_IDLE;
            end
            else if (paddr == ADDR_PRESCALE)
            begin
                prdata_reg[7:0] <= prescale_reg;
            end
            else if (paddr == ADDR_RAW_INT)
            begin
                prdata_reg[OVERRUN_CLEAR_BIT] <= overrun_reg;
                prdata_reg[RX_TIMEOUT_CLEAR_BIT] <= rxTimeout_reg;
            end
            else if (paddr != ADDR_INT_CLEAR)
            begin
                pslverr_reg <= 1'b1;
            end
        end
    end

    // Transmit FIFO: a write while full is dropped
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            txWr_reg <= '0;
            txRd_reg <= '0;
        end
        else
        begin
            if (wrAccess && paddr == ADDR_DATA && !txFull)
            begin
                txMem[txWr_reg[PW-1:0]] <= pwdata[WORD_WIDTH-1:0];
                txWr_reg <= txWr_reg + 1'b1;
            end
            if (txPop_reg)
            begin
                txRd_reg <= txRd_reg + 1'b1;
            end
        end
    end

    // Receive FIFO and overrun; the new word is lost when the FIFO is full
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rxWr_reg <= '0;
            rxRd_reg <= '0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            if (rxPush_reg && !rxFull)
            begin
                rxMem[rxWr_reg[PW-1:0]] <= rxWord_reg;
                rxWr_reg <= rxWr_reg + 1'b1;
            end
            if (rxPop)
            begin
                rxRd_reg <= rxRd_reg + 1'b1;
            end
            // A new overrun beats a clear in the same cycle
            overrun_reg <= (rxPush_reg && rxFull)
                || (overrun_reg && !(icrWrite && pwdata[OVERRUN_CLEAR_BIT]));
        end
    end

    // Receive timeout
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            toCnt_reg <= 24'h000000;
            rxTimeout_reg <= 1'b0;
        end
        else
        begin
            if (rxEmpty || rxPop)
            begin
                toCnt_reg <= 24'h000000;
            end
            else if (toCnt_reg != toLimit)
            begin
                toCnt_reg <= toCnt_reg + 24'h000001;
            end
            rxTimeout_reg <= (toCnt_reg == toLimit && !rxEmpty)
                || (rxTimeout_reg && !(icrWrite && pwdata[RX_TIMEOUT_CLEAR_BIT]));
        end
    end

    // Receive pin: three stages, a change counts once the last two agree
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rxSync_reg <= 3'h0;
            rxBit_reg <= 1'b0;
        end
        else
        begin
            rxSync_reg <= {rxSync_reg[1:0], rxDataLine};
            if (rxSync_reg[1] == rxSync_reg[2])
            begin
                rxBit_reg <= rxSync_reg[2];
            end
        end
    end

    // Half-period timer
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            divCnt_reg <= 16'h0000;
        end
        else if (tick)
        begin
            divCnt_reg <= 16'h0000;
        end
        else
        begin
            divCnt_reg <= divCnt_reg + 16'h0001;
        end
    end
    assign tick = divCnt_reg >= halfLimit(prescale_reg, ctrl0_reg.serialClockRate);

    // Serial engine; one action per half period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            sck_reg <= 1'b0;
            sel_reg <= 1'b1;
            fs_reg <= 1'b0;
            oe_reg <= 1'b0;
            txBit_reg <= 1'b0;
            txPop_reg <= 1'b0;
            rxPush_reg <= 1'b0;
            pendPush_reg <= 1'b0;
            edge_reg <= 6'h00;
            tailCnt_reg <= 2'h0;
            txShift_reg <= '0;
            rxShift_reg <= '0;
            rxWord_reg <= '0;
        end
        else
        begin
            txPop_reg <= 1'b0;
            rxPush_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    sck_reg <= pulseMode ? 1'b0 : ctrl0_reg.cpol;
                    sel_reg <= 1'b1;
                    fs_reg <= 1'b0;
                    oe_reg <= 1'b0;
                    if (tick && enable_reg && !txEmpty)
                    begin
                        txShift_reg <= txMem[txRd_reg[PW-1:0]];
                        txPop_reg <= 1'b1;
                        edge_reg <= 6'h00;
                        if (pulseMode)
                        begin
                            fs_reg <= 1'b1;
                            sck_reg <= 1'b1;
                            state_reg <= ST_FRAME;
                        end
                        else
                        begin
                            sel_reg <= 1'b0;
                            oe_reg <= 1'b1;
                            state_reg <= ST_LEAD;
                        end
                    end
                end
                ST_LEAD:
                begin
                    if (tick)
                    begin
                        txBit_reg <= txShift_reg[msb];
                        state_reg <= ST_SHIFT;
                        if (ctrl0_reg.cpha)
                        begin
                            sck_reg <= !sck_reg;
                            edge_reg <= 6'h01;
                        end
                    end
                end
                ST_FRAME:
                begin
                    if (tick)
                    begin
                        sck_reg <= 1'b0;
                        oe_reg <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        sck_reg <= !sck_reg;
                        edge_reg <= edge_reg + 6'h01;
                        if (edge_reg == 6'h00 && phaseLate)
                        begin
                            fs_reg <= 1'b0;
                            txBit_reg <= txShift_reg[msb];
                        end
                        else if (edge_reg[0] != phaseLate && edge_reg != lastEdge)
                        begin
                            txShift_reg <= txShift_reg << 1;
                            txBit_reg <= txShift_reg[msb - 4'h1];
                        end
                        // Even edges sample in phase 0, odd ones in phase 1
                        if (edge_reg[0] == phaseLate)
                        begin
                            rxShift_reg <= {rxShift_reg[WORD_WIDTH-2:0], rxBit_reg};
                            if (edge_reg >= lastEdge - 6'h01)
                            begin
                                rxWord_reg <= {rxShift_reg[WORD_WIDTH-2:0], rxBit_reg};
                                rxPush_reg <= !pulseMode;
                                pendPush_reg <= pulseMode;
                            end
                        end
                        if (edge_reg == lastEdge)
                        begin
                            if (!pulseMode && ctrl0_reg.cpha && enable_reg && !txEmpty)
                            begin
                                txShift_reg <= txMem[txRd_reg[PW-1:0]];
                                txPop_reg <= 1'b1;
                                edge_reg <= 6'h00;
                            end
                            else
                            begin
                                state_reg <= ST_TAIL;
                                tailCnt_reg <= (ctrl0_reg.cpha && !pulseMode) ? 2'h2 : 2'h1;
                            end
                        end
                    end
                end
                ST_TAIL:
                begin
                    if (tick)
                    begin
                        tailCnt_reg <= tailCnt_reg - 2'h1;
                        if (tailCnt_reg == 2'h1)
                        begin
                            state_reg <= ST_IDLE;
                            if (pulseMode)
                            begin
                                sck_reg <= 1'b1;
                                rxPush_reg <= pendPush_reg;
                                pendPush_reg <= 1'b0;
                                if (enable_reg && !txEmpty)
                                begin
                                    txShift_reg <= txMem[txRd_reg[PW-1:0]];
                                    txPop_reg <= 1'b1;
                                    fs_reg <= 1'b1;
                                    edge_reg <= 6'h00;
                                    state_reg <= ST_FRAME;
                                end
                            end
                            else
                            begin
                                sel_reg <= 1'b1;
                                oe_reg <= 1'b0;
                            end
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks
    logic [1:0] fsTicks_reg;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !fs_reg)
        begin
            fsTicks_reg <= 2'h0;
        end
        else if (tick && fsTicks_reg != 2'h3)
        begin
            fsTicks_reg <= fsTicks_reg + 2'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence seqIdleSettled;
        state_reg == ST_IDLE && $past(state_reg) == ST_IDLE;
    endsequence
    sequence seqSpiStart;
        state_reg == ST_IDLE && tick && enable_reg && !txEmpty && !pulseMode;
    endsequence

    AST_OVERRUN_CLEAR: assert property (icrWrite && pwdata[0] && !(rxPush_reg && rxFull)
        |=> !overrun_reg) else $error("overrun flag not cleared");
    AST_TIMEOUT_CLEAR: assert property (icrWrite && pwdata[1] && toCnt_reg != toLimit
        |=> !rxTimeout_reg) else $error("timeout flag not cleared");
    AST_TIMEOUT_RESTART: assert property (rxPop |=> toCnt_reg == 24'h000000)
        else $error("timeout count not restarted");
    AST_PULSE_IDLE: assert property (seqIdleSettled and pulseMode |-> !sck_reg && !fs_reg && !oe_reg)
        else $error("pulse idle levels wrong");
    AST_PULSE_WIDTH: assert property ($fell(fs_reg) && pulseMode |-> fsTicks_reg == 2'h2)
        else $error("frame pulse not one clock period");
    // Idle clock follows the polarity one cycle late, so a fresh write is not a fault
    AST_SPI_IDLE_CLOCK: assert property (seqIdleSettled and !pulseMode
        |=> sck_reg == $past(ctrl0_reg.cpol))
        else $error("idle clock level wrong");
    AST_SPI_IDLE_SELECT: assert property (seqIdleSettled and !pulseMode |-> sel_reg && !oe_reg)
        else $error("idle select or output wrong");
    AST_SPI_START: assert property (seqSpiStart |=> !sel_reg && oe_reg ##1 !sel_reg)
        else $error("transfer start wrong");
    AST_PHASE0_REENTRY: assert property ($rose(state_reg == ST_SHIFT) && !phaseLate
        |-> $past(state_reg) == ST_LEAD) else $error("phase 0 word without select pulse");
endmodule

/* pkg/ssf_pkg.sv */
// Constants, field layouts and state type for the synchronous serial frame block
package ssf_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL0 = 32'h40040000;
    localparam logic [31:0] ADDR_CTRL1 = 32'h40040004;
    localparam logic [31:0] ADDR_DATA = 32'h40040008;
    localparam logic [31:0] ADDR_STATUS = 32'h4004000C;
    localparam logic [31:0] ADDR_PRESCALE = 32'h40040010;
    localparam logic [31:0] ADDR_RAW_INT = 32'h40040018;
    localparam logic [31:0] ADDR_INT_CLEAR = 32'h40040020;
    // Field positions
    localparam int OVERRUN_CLEAR_BIT = 0;
    localparam int RX_TIMEOUT_CLEAR_BIT = 1;
    localparam int ENABLE_BIT = 1;
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_NOT_FULL = 1;
    localparam int ST_RX_NOT_EMPTY = 2;
    localparam int ST_RX_FULL = 3;
    localparam int ST_BUSY = 4;
    // Frame formats
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_PULSE = 2'h1;
    // Reset values
    localparam logic [15:0] CTRL0_RESET = 16'h0007;
    localparam logic [7:0] PRESCALE_RESET = 8'h02;
    // Receive timeout in serial bit times, and half periods per bit
    localparam logic [23:0] RX_TIMEOUT_BITS = 24'h000020;
    localparam logic [23:0] HALVES_PER_BIT = 24'h000002;
    // Shortest half period in ref_clk cycles, so registered pops settle
    localparam logic [15:0] MIN_HALF_CYCLES = 16'h0002;

    typedef struct packed {
        logic [7:0] serialClockRate;
        logic cpha;
        logic cpol;
        logic [1:0] format;
        logic [3:0] dataSize;
    } ssf_ctrl0_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_FRAME,
        ST_SHIFT,
        ST_TAIL
    } ssf_state_t;
endpackage

/* sim/ssf_slave_model.sv */
// Behavioural off-chip serial slave for the frame block bench
`timescale 1ns/1ns
module ssf_slave_model
(
    // Link
    input wire logic serialClock,
    input wire logic slaveSelect_b,
    input wire logic framePulse,
    input wire logic txDataLine,
    output logic rxDataLine,
    // Setup and observation
    input wire logic pulseMode,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [3:0] dataSize,
    input wire logic [15:0] reply,
    output logic [15:0] heard
);
    int idx = 0;
    int left = 0;
    initial rxDataLine = 1'b0;
    initial heard = 16'h0000;
    // A released line shows the inverse, so a stale bit cannot pass
    always @(posedge slaveSelect_b)
        if (!pulseMode)
            rxDataLine = ~rxDataLine;
    always @(negedge slaveSelect_b)
    begin
        idx = dataSize + 1;
        if (!pulseMode && !cpha)
        begin
            idx = idx - 1;
            rxDataLine = reply[idx];
        end
    end
    // Settle 1 ns so the pulse and the clock are seen together; the pulse format
    // counts its bits, so the falls around a frame are not taken as data
    always @(serialClock)
    begin
        #1;
        if (pulseMode ? !serialClock : serialClock == (cpol == cpha))
        begin
            if (!pulseMode || (left > 0 && !framePulse))
            begin
                heard = {heard[14:0], txDataLine};
                left = left - 1;
            end
        end
        else if (pulseMode && framePulse)
        begin
            idx = dataSize + 1;
            left = dataSize + 1;
        end
        else
        begin
            if (idx == 0)
                idx = dataSize + 1;
            idx = idx - 1;
            rxDataLine = reply[idx];
        end
    end
endmodule

/* sim/tb.sv */
// Self-checking bench for the serial frame block: registers and link formats
`timescale 1ns/1ns
module tb;
    import ssf_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, serialClock, slaveSelect_b, framePulse;
    logic txDataLine, txDataLineOe, rxDataLine, err;
    logic pulseMode = 1'b0;
    ssf_ctrl0_t ctrl = CTRL0_RESET;
    logic [15:0] reply, heard, word, mask;
    int n_mismatch = 0;
    int samples_checked = 0;
    int selRise = 0;
    int pulseRise = 0;
    `define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("FAIL %0t got %h exp %h", $time, a, b); \
        end \
    end
    ssf_serial_port dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialClock(serialClock), .slaveSelect_b(slaveSelect_b),
        .framePulse(framePulse), .txDataLine(txDataLine), .txDataLineOe(txDataLineOe),
        .rxDataLine(rxDataLine));
    ssf_slave_model slave_u (.serialClock(serialClock), .slaveSelect_b(slaveSelect_b),
        .framePulse(framePulse), .txDataLine(txDataLine), .rxDataLine(rxDataLine),
        .pulseMode(pulseMode), .cpol(ctrl.cpol), .cpha(ctrl.cpha),
        .dataSize(ctrl.dataSize), .reply(reply), .heard(heard));
    always #4 ref_clk = ~ref_clk;
    always @(posedge slaveSelect_b) selRise++;
    always @(posedge framePulse) pulseRise++;
    // Called just after a rising edge; returns one edge after release
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic waitIdle();
        int k = 0;
        do
        begin
            repeat (16) @(posedge ref_clk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            k++;
        end
        while ((rd[ST_BUSY] !== 1'b0 || rd[ST_TX_EMPTY] !== 1'b1) && k < 400);
        `CHK(k < 400, 1'b1)
    endtask
    task automatic runMode(input logic [1:0] fmt, input logic pol, input logic pha);
        int k;
        ctrl.format = fmt;
        ctrl.cpol = pol;
        ctrl.cpha = pha;
        // Pulse runs at half rate so the clock-rate field is exercised too
        ctrl.serialClockRate = 8'(fmt == FMT_PULSE);
        ctrl.dataSize = 4'(3 + $urandom_range(12));
        pulseMode = (fmt == FMT_PULSE);
        mask = 16'((32'h1 << (ctrl.dataSize + 1)) - 1);
        reply = 16'($urandom);
        apb(1'b1, ADDR_CTRL1, 32'h0);
        apb(1'b1, ADDR_CTRL0, {16'h0, ctrl});
        repeat (20) @(posedge ref_clk);
        `CHK(serialClock, pulseMode ? 1'b0 : pol)
        `CHK(txDataLineOe, 1'b0)
        `CHK(slaveSelect_b, 1'b1)
        selRise = 0;
        pulseRise = 0;
        word = 16'($urandom);
        apb(1'b1, ADDR_DATA, 32'($urandom_range(16'hFFFF)));
        apb(1'b1, ADDR_DATA, {16'h0, word});
        // Enable after queueing so the two words run back to back
        apb(1'b1, ADDR_CTRL1, 32'h1 << ENABLE_BIT);
        for (k = 0; k < 40 && !pulseMode && slaveSelect_b !== 1'b0; k++)
            @(posedge ref_clk);
        `CHK(txDataLineOe, !pulseMode)
        waitIdle();
        repeat (40) @(posedge ref_clk);
        `CHK(heard & mask, word & mask)
        `CHK(selRise, pulseMode ? 0 : (pha ? 1 : 2))
        `CHK(pulseRise, pulseMode ? 2 : 0)
        `CHK(serialClock, pulseMode ? 1'b0 : pol)
        for (k = 0; k < 2; k++)
        begin
            apb(1'b0, ADDR_DATA, 32'h0);
            `CHK(rd[15:0] & mask, reply & mask)
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        rd = $urandom(32'hE835AA32);
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        `CHK(rd[15:0], CTRL0_RESET)
        apb(1'b0, ADDR_PRESCALE, 32'h0);
        `CHK(rd[7:0], PRESCALE_RESET)
        // Half period of 8 cycles leaves room for the input synchroniser
        apb(1'b1, ADDR_PRESCALE, 32'h10);
        runMode(FMT_PULSE, 1'b0, 1'b0);
        for (int m = 0; m < 4; m++)
            runMode(FMT_SPI, m[1], m[0]);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b1, ADDR_DATA, 32'h5A5);
            if (i == 7)
                waitIdle();
        end
        waitIdle();
        apb(1'b0, ADDR_RAW_INT, 32'h0);
        `CHK(rd[1:0], 2'h3)
        apb(1'b1, ADDR_INT_CLEAR, 32'h1); // Reserved bits written as zero
        apb(1'b0, ADDR_RAW_INT, 32'h0);
        `CHK(rd[1:0], 2'h2)
        repeat (8) apb(1'b0, ADDR_DATA, 32'h0);
        apb(1'b1, ADDR_INT_CLEAR, 32'h2);
        repeat (600) @(posedge ref_clk);
        apb(1'b0, ADDR_RAW_INT, 32'h0);
        `CHK(rd[1:0], 2'h0)
        apb(1'b1, ADDR_DATA, 32'h3C3);
        waitIdle();
        apb(1'b0, ADDR_RAW_INT, 32'h0);
        `CHK(rd[1], 1'b0)
        repeat (600) @(posedge ref_clk);
        apb(1'b0, ADDR_RAW_INT, 32'h0);
        `CHK(rd[1], 1'b1)
        apb(1'b0, 32'h4004003C, 32'h0);
        `CHK(err, 1'b1)
        summarize();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule
